/* common/chps_pkg.sv */
`default_nettype none
package chps_pkg;
   // Operating modes of the card
   typedef enum logic [1:0] {
      CHPS_MODE_MEM = 2'h0,
      CHPS_MODE_IO = 2'h1,
      CHPS_MODE_IDE = 2'h2
   } chps_mode_t;

   // Access width decoded from the card enables
   typedef enum logic [1:0] {
      CHPS_ACC_IDLE = 2'h0,
      CHPS_ACC_BYTE_EVEN = 2'h1,
      CHPS_ACC_BYTE_ODD = 2'h2,
      CHPS_ACC_WORD = 2'h3
   } chps_acc_t;

   // IDE register group selected by the chip selects
   typedef enum logic [1:0] {
      CHPS_SEL_NONE = 2'h0,
      CHPS_SEL_TASK = 2'h1,
      CHPS_SEL_ALT_STATUS = 2'h2,
      CHPS_SEL_DEV_CTRL = 2'h3
   } chps_sel_t;

   // Host strobe engine states
   typedef enum logic [1:0] {
      CHPS_HS_IDLE = 2'h0,
      CHPS_HS_SETUP = 2'h1,
      CHPS_HS_STROBE = 2'h2,
      CHPS_HS_HOLD = 2'h3
   } chps_hs_t;

   localparam int unsigned CHPS_DATA_W = 16;
   localparam int unsigned CHPS_ADDR_W = 11;
   // Strobe low time 150 ns at 50 ns clock period, rounded up
   localparam int unsigned CHPS_STROBE_NS = 150;
   localparam int unsigned CHPS_CLK_NS = 50;
   localparam logic [3:0] CHPS_STROBE_CYC =
      4'((CHPS_STROBE_NS + CHPS_CLK_NS - 1) / CHPS_CLK_NS);
   // Read return path: device sync and drive, then host sync
   localparam logic [3:0] CHPS_TURN_CYC = 4'h4;
   localparam logic [15:0] CHPS_DATA_RST = 16'h0000;
endpackage
`default_nettype wire

/* common/chps_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface chps_if;
   logic card_enable_low_byte_n;
   logic card_enable_high_byte_n;
   logic task_reg_select_n;
   logic ctrl_reg_select_n;
   logic dma_acknowledge_n;
   logic cable_select_n;
   logic io_write_strobe_n;
   logic io_read_strobe_n;
   logic output_enable_n;
   logic write_enable_n;
   logic byte_address_lsb;
   logic card_detect_first_n;
   logic card_detect_second_n;
   logic [15:0] host_data;
   logic [15:0] card_data;
   logic card_data_oe_n;

   modport dev (
      input card_enable_low_byte_n, card_enable_high_byte_n, task_reg_select_n,
      input ctrl_reg_select_n, dma_acknowledge_n, cable_select_n,
      input io_write_strobe_n, io_read_strobe_n, output_enable_n, write_enable_n,
      input byte_address_lsb, host_data,
      output card_detect_first_n, card_detect_second_n, card_data, card_data_oe_n
   );
   modport host (
      output card_enable_low_byte_n, card_enable_high_byte_n, task_reg_select_n,
      output ctrl_reg_select_n, dma_acknowledge_n, cable_select_n,
      output io_write_strobe_n, io_read_strobe_n, output_enable_n, write_enable_n,
      output byte_address_lsb, host_data,
      input card_detect_first_n, card_detect_second_n, card_data, card_data_oe_n
   );
endinterface
`default_nettype wire

/* rtl/chps_dev.sv */
`timescale 1ns/1ps
`default_nettype none
module chps_dev (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   chps_if.dev bus,
   input wire chps_pkg::chps_mode_t mode_i,
   input wire logic udma_active_i,
   input wire logic [15:0] read_data_i,
   output logic card_seated_o,
   output logic is_master_o,
   output logic write_valid_o,
   output logic [15:0] write_data_o,
   output chps_pkg::chps_acc_t write_acc_o,
   output chps_pkg::chps_sel_t write_sel_o,
   output logic read_valid_o,
   output chps_pkg::chps_acc_t read_acc_o,
   output chps_pkg::chps_sel_t read_sel_o,
   output logic burst_stop_o
);
   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers, two flops each
   localparam int unsigned NP = 9;
   logic [NP-1:0] pin_a;
   logic [NP-1:0] pin_s1_q;
   logic [NP-1:0] pin_s2_q;
   logic [15:0] dat_s1_q;
   logic [15:0] dat_s2_q;
   assign pin_a = {bus.card_enable_low_byte_n, bus.card_enable_high_byte_n,
                   bus.task_reg_select_n, bus.ctrl_reg_select_n,
                   bus.cable_select_n, bus.io_write_strobe_n,
                   bus.io_read_strobe_n, bus.output_enable_n,
                   bus.write_enable_n};

   genvar g;
   generate
      for (g = 0; g < NP; g++) begin : g_sync
         always_ff @(posedge mclk_i) begin
            if (!rst_n_i) begin
               pin_s1_q[g] <= 1'b1;
               pin_s2_q[g] <= 1'b1;
            end else begin
               pin_s1_q[g] <= pin_a[g];
               pin_s2_q[g] <= pin_s1_q[g];
            end
         end
      end
   endgenerate

   logic lsb_s1_q;
   logic lsb_s2_q;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         dat_s1_q <= chps_pkg::CHPS_DATA_RST;
         dat_s2_q <= chps_pkg::CHPS_DATA_RST;
         lsb_s1_q <= 1'b0;
         lsb_s2_q <= 1'b0;
      end else begin
         dat_s1_q <= bus.host_data;
         dat_s2_q <= dat_s1_q;
         lsb_s1_q <= bus.byte_address_lsb;
         lsb_s2_q <= lsb_s1_q;
      end
   end

   logic ce1_n;
   logic ce2_n;
   logic cs0_n;
   logic cs1_n;
   logic cable_select_n_n;
   logic io_write_strobe_n_n;
   logic io_read_strobe_n_n;
   logic oe_n;
   logic we_n;
   assign {ce1_n, ce2_n, cs0_n, cs1_n, cable_select_n_n, io_write_strobe_n_n, io_read_strobe_n_n, oe_n, we_n} = pin_s2_q;

   ////////////////////////////////////////////////////////////////////////
   // Decoding
   function automatic chps_pkg::chps_acc_t acc_dec(input logic c1_n, input logic c2_n,
                                                  input logic a0);
      if (!c1_n && !c2_n) begin
         acc_dec = chps_pkg::CHPS_ACC_WORD;
      end else if (!c2_n) begin
         acc_dec = chps_pkg::CHPS_ACC_BYTE_ODD;
      end else if (!c1_n) begin
         acc_dec = a0 ? chps_pkg::CHPS_ACC_BYTE_ODD : chps_pkg::CHPS_ACC_BYTE_EVEN;
      end else begin
         acc_dec = chps_pkg::CHPS_ACC_IDLE;
      end
   endfunction

   function automatic chps_pkg::chps_sel_t sel_dec(input logic c0_n, input logic c1_n,
                                                  input logic wr);
      if (!c0_n) begin
         sel_dec = chps_pkg::CHPS_SEL_TASK;
      end else if (!c1_n) begin
         sel_dec = wr ? chps_pkg::CHPS_SEL_DEV_CTRL : chps_pkg::CHPS_SEL_ALT_STATUS;
      end else begin
         sel_dec = chps_pkg::CHPS_SEL_NONE;
      end
   endfunction

   logic ide;
   logic dma_s1_q;
   logic dma_n_q;
   logic dma_mode;
   chps_pkg::chps_acc_t acc_now;
   assign ide = (mode_i == chps_pkg::CHPS_MODE_IDE);
   // DMA cycles ignore chip selects and are always full width
   assign dma_mode = ide && !dma_n_q;
   assign acc_now = (ide || dma_mode) ? chps_pkg::CHPS_ACC_WORD
                                      : acc_dec(ce1_n, ce2_n, lsb_s2_q);

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         dma_s1_q <= 1'b1;
         dma_n_q <= 1'b1;
      end else begin
         dma_s1_q <= bus.dma_acknowledge_n;
         dma_n_q <= dma_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write strobe: capture on trailing edge, or stop request under UDMA
   logic io_write_strobe_n_prev_q;
   logic io_read_strobe_n_prev_q;
   logic wr_strobe;
   logic wr_rise;
   logic wr_sel_ok;
   assign wr_strobe = (mode_i == chps_pkg::CHPS_MODE_MEM) ? we_n : io_write_strobe_n_n;
   assign wr_sel_ok = ide ? (!cs0_n || !cs1_n || dma_mode) : (!ce1_n || !ce2_n);
   assign wr_rise = wr_strobe && !io_write_strobe_n_prev_q;

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         io_write_strobe_n_prev_q <= 1'b1;
      end else begin
         io_write_strobe_n_prev_q <= wr_strobe;
      end
   end

   logic sel_wr_q;
   chps_pkg::chps_acc_t acc_wr_q;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         sel_wr_q <= 1'b0;
         acc_wr_q <= chps_pkg::CHPS_ACC_IDLE;
      end else if (!wr_strobe && io_write_strobe_n_prev_q) begin
         // Selects sampled at the leading edge, held through the strobe
         sel_wr_q <= wr_sel_ok;
         acc_wr_q <= acc_now;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         write_valid_o <= 1'b0;
         write_data_o <= chps_pkg::CHPS_DATA_RST;
         write_acc_o <= chps_pkg::CHPS_ACC_IDLE;
         write_sel_o <= chps_pkg::CHPS_SEL_NONE;
      end else begin
         write_valid_o <= wr_rise && sel_wr_q && !(ide && udma_active_i);
         if (wr_rise && sel_wr_q && !(ide && udma_active_i)) begin
            // Odd byte copied up from the low lines when an 8-bit host used them
            write_data_o <= (acc_wr_q == chps_pkg::CHPS_ACC_BYTE_ODD && !ce1_n && ce2_n)
                            ? {dat_s2_q[7:0], dat_s2_q[7:0]} : dat_s2_q;
            write_acc_o <= acc_wr_q;
            write_sel_o <= dma_mode ? chps_pkg::CHPS_SEL_NONE
                         : (ide ? sel_dec(cs0_n, cs1_n, 1'b1) : chps_pkg::CHPS_SEL_NONE);
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         burst_stop_o <= 1'b0;
      end else begin
         burst_stop_o <= ide && udma_active_i && !io_write_strobe_n_n && io_write_strobe_n_prev_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read side
   logic rd_strobe;
   logic rd_ok;
   assign rd_strobe = (mode_i == chps_pkg::CHPS_MODE_MEM) ? oe_n : io_read_strobe_n_n;
   assign rd_ok = !rd_strobe && !(ide && udma_active_i) &&
                  (ide ? (!cs0_n || !cs1_n || dma_mode) : (!ce1_n || !ce2_n));

   // Previous level of whichever read strobe the mode uses
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         io_read_strobe_n_prev_q <= 1'b1;
      end else begin
         io_read_strobe_n_prev_q <= rd_strobe;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         read_valid_o <= 1'b0;
         read_acc_o <= chps_pkg::CHPS_ACC_IDLE;
         read_sel_o <= chps_pkg::CHPS_SEL_NONE;
         bus.card_data <= chps_pkg::CHPS_DATA_RST;
         bus.card_data_oe_n <= 1'b1;
      end else begin
         read_valid_o <= rd_ok && io_read_strobe_n_prev_q;
         read_acc_o <= rd_ok ? acc_now : chps_pkg::CHPS_ACC_IDLE;
         read_sel_o <= (rd_ok && ide && !dma_mode) ? sel_dec(cs0_n, cs1_n, 1'b0)
                                                  : chps_pkg::CHPS_SEL_NONE;
         bus.card_data_oe_n <= !rd_ok;
         // Odd byte presented on low lines for 8-bit hosts
         bus.card_data <= (acc_now == chps_pkg::CHPS_ACC_BYTE_ODD && !ce1_n && ce2_n)
                          ? {read_data_i[15:8], read_data_i[15:8]} : read_data_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Card detect and master/slave
   assign bus.card_detect_first_n = 1'b0;
   assign bus.card_detect_second_n = 1'b0;
   assign card_seated_o = 1'b1;

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         is_master_o <= 1'b0;
      end else begin
         is_master_o <= ide && !cable_select_n_n;
      end
   end
endmodule
`default_nettype wire

/* rtl/chps_host.sv */
`timescale 1ns/1ps
`default_nettype none
module chps_host (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   chps_if.host bus,
   input wire chps_pkg::chps_mode_t mode_i,
   input wire logic req_i,
   input wire logic req_write_i,
   input wire logic req_word_i,
   input wire logic req_lsb_i,
   input wire logic req_ctrl_i,
   input wire logic req_dma_i,
   input wire logic req_master_i,
   input wire logic [15:0] req_data_i,
   input wire logic stop_i,
   output logic req_ready_o,
   output logic done_o,
   output logic [15:0] rd_data_o,
   output logic card_present_o
);
   chps_pkg::chps_hs_t st_q;
   logic [3:0] cnt_q;
   logic wr_q;
   logic word_q;
   logic lsb_q;
   logic ctrl_q;
   logic dma_q;
   logic [15:0] wdat_q;
   logic cd1_s1_q;
   logic cd1_s2_q;
   logic cd2_s1_q;
   logic cd2_s2_q;
   logic [15:0] rd_s1_q;
   logic [15:0] rd_s2_q;
   logic ide;

   assign ide = (mode_i == chps_pkg::CHPS_MODE_IDE);
   assign req_ready_o = (st_q == chps_pkg::CHPS_HS_IDLE);

   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         st_q <= chps_pkg::CHPS_HS_IDLE;
         cnt_q <= 4'h0;
         wr_q <= 1'b0;
         word_q <= 1'b0;
         lsb_q <= 1'b0;
         ctrl_q <= 1'b0;
         dma_q <= 1'b0;
         wdat_q <= chps_pkg::CHPS_DATA_RST;
         done_o <= 1'b0;
         rd_data_o <= chps_pkg::CHPS_DATA_RST;
      end else begin
         done_o <= 1'b0;
         case (st_q)
            chps_pkg::CHPS_HS_IDLE: begin
               if (req_i) begin
                  wr_q <= req_write_i;
                  word_q <= req_word_i || (ide && req_dma_i);
                  lsb_q <= req_lsb_i;
                  ctrl_q <= req_ctrl_i;
                  dma_q <= ide && req_dma_i;
                  wdat_q <= req_data_i;
                  st_q <= chps_pkg::CHPS_HS_SETUP;
               end
            end
            chps_pkg::CHPS_HS_SETUP: begin
               cnt_q <= chps_pkg::CHPS_STROBE_CYC;
               st_q <= chps_pkg::CHPS_HS_STROBE;
            end
            chps_pkg::CHPS_HS_STROBE: begin
               if (cnt_q == 4'h1) begin
                  cnt_q <= chps_pkg::CHPS_TURN_CYC;
                  st_q <= chps_pkg::CHPS_HS_HOLD;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            chps_pkg::CHPS_HS_HOLD: begin
               // Enables held until the card's steered data has come back
               if (cnt_q == 4'h1) begin
                  rd_data_o <= rd_s2_q;
                  done_o <= 1'b1;
                  st_q <= chps_pkg::CHPS_HS_IDLE;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            default: begin
               st_q <= chps_pkg::CHPS_HS_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drive
   logic active;
   logic strobe;
   assign active = (st_q != chps_pkg::CHPS_HS_IDLE);
   assign strobe = (st_q == chps_pkg::CHPS_HS_STROBE);

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         bus.card_enable_low_byte_n <= 1'b1;
         bus.card_enable_high_byte_n <= 1'b1;
         bus.task_reg_select_n <= 1'b1;
         bus.ctrl_reg_select_n <= 1'b1;
         bus.dma_acknowledge_n <= 1'b1;
         bus.io_write_strobe_n <= 1'b1;
         bus.io_read_strobe_n <= 1'b1;
         bus.output_enable_n <= 1'b1;
         bus.write_enable_n <= 1'b1;
         bus.byte_address_lsb <= 1'b0;
         bus.host_data <= chps_pkg::CHPS_DATA_RST;
      end else begin
         // Outside IDE mode, word uses both enables, byte uses the first with address lsb; IDE mode leaves both negated
         bus.card_enable_low_byte_n <= !(active && !ide);
         bus.card_enable_high_byte_n <= !(active && !ide && word_q);
         bus.byte_address_lsb <= lsb_q;
         bus.task_reg_select_n <= !(active && ide && !dma_q && !ctrl_q);
         bus.ctrl_reg_select_n <= !(active && ide && !dma_q && ctrl_q);
         bus.dma_acknowledge_n <= !(active && dma_q);
         bus.io_write_strobe_n <= !((strobe && wr_q && mode_i != chps_pkg::CHPS_MODE_MEM)
                                   || (ide && stop_i));
         bus.io_read_strobe_n <= !(strobe && !wr_q && mode_i != chps_pkg::CHPS_MODE_MEM);
         bus.output_enable_n <= !(strobe && !wr_q && mode_i == chps_pkg::CHPS_MODE_MEM);
         bus.write_enable_n <= !(strobe && wr_q && mode_i == chps_pkg::CHPS_MODE_MEM);
         bus.host_data <= wdat_q;
      end
   end

   // Master strap: grounded selects master, otherwise tied low in card modes
   assign bus.cable_select_n = ide ? !req_master_i : 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         cd1_s1_q <= 1'b1;
         cd1_s2_q <= 1'b1;
         cd2_s1_q <= 1'b1;
         cd2_s2_q <= 1'b1;
         rd_s1_q <= chps_pkg::CHPS_DATA_RST;
         rd_s2_q <= chps_pkg::CHPS_DATA_RST;
         card_present_o <= 1'b0;
      end else begin
         cd1_s1_q <= bus.card_detect_first_n;
         cd1_s2_q <= cd1_s1_q;
         cd2_s1_q <= bus.card_detect_second_n;
         cd2_s2_q <= cd2_s1_q;
         rd_s1_q <= bus.card_data;
         rd_s2_q <= rd_s1_q;
         card_present_o <= !cd1_s2_q && !cd2_s2_q;
      end
   end
endmodule
`default_nettype wire

/* bench/chps_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module chps_checker (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic card_enable_low_byte_n,
   input wire logic task_reg_select_n,
   input wire logic ctrl_reg_select_n,
   input wire logic dma_acknowledge_n,
   input wire logic io_write_strobe_n,
   input wire logic io_read_strobe_n,
   input wire logic output_enable_n,
   input wire logic card_detect_first_n,
   input wire logic card_detect_second_n,
   input wire logic [15:0] host_data,
   input wire logic card_data_oe_n
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   ////////////////////////////////////////////////////////////////////////////////
   chk_dma_sel_off: assert property (!dma_acknowledge_n |->
      task_reg_select_n && ctrl_reg_select_n)
      else $error("chip select active during dma");
   chk_detect_tied: assert property (!card_detect_first_n && !card_detect_second_n)
      else $error("card detect not low");
   chk_read_drive: assert property (!card_data_oe_n && $past(card_data_oe_n) |->
      !$past(output_enable_n, 2) || !$past(io_read_strobe_n, 2))
      else $error("card drives data without read strobe");
   chk_read_release: assert property ($rose(output_enable_n) && io_read_strobe_n |->
      ##[1:5] card_data_oe_n)
      else $error("card data not released");
   chk_oe_width: assert property ($fell(output_enable_n) |->
      (!output_enable_n)[*3] ##1 output_enable_n)
      else $error("output enable strobe width");
   chk_ior_width: assert property ($fell(io_read_strobe_n) |->
      (!io_read_strobe_n)[*3] ##1 io_read_strobe_n)
      else $error("io read strobe width");
   chk_ior_selected: assert property ($fell(io_read_strobe_n) |->
      !card_enable_low_byte_n || !task_reg_select_n || !ctrl_reg_select_n || !dma_acknowledge_n)
      else $error("io read without select");
   chk_wdata_held: assert property (!io_write_strobe_n && !$past(io_write_strobe_n) |->
      $stable(host_data))
      else $error("write data moved under strobe");
   chk_oe_enabled: assert property ($fell(output_enable_n) |-> !card_enable_low_byte_n)
      else $error("output enable without card enable");
endmodule
`default_nettype wire

/* bench/tb_card_host_pin_select_logic.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_card_host_pin_select_logic;
   typedef struct {
      logic [1:0] mode;
      logic wr;
      logic word;
      logic lsb;
      logic ctrl;
      logic [15:0] data;
      logic [1:0] acc;
      logic [1:0] sel;
   } chps_row_t;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   chps_pkg::chps_mode_t mode = chps_pkg::CHPS_MODE_MEM;
   logic udma = 1'b0;
   logic [15:0] rd_src = 16'h0000;
   logic req = 1'b0;
   logic req_wr = 1'b0;
   logic req_word = 1'b0;
   logic req_lsb = 1'b0;
   logic req_ctrl = 1'b0;
   logic req_dma = 1'b0;
   logic req_master = 1'b0;
   logic [15:0] req_data = 16'h0000;
   logic stop = 1'b0;
   logic seated, master, wv, rv, bstop, ready, done, present;
   logic [15:0] wdat, rdat;
   chps_pkg::chps_acc_t wacc, racc, c_wacc, c_racc;
   chps_pkg::chps_sel_t wsel, rsel, c_wsel, c_rsel;
   logic [15:0] c_wdat;
   logic wv_seen, rv_seen, dn_seen, bs_seen;
   int n_fail = 0;
   int tests_run = 0;
   int cyc = 0;
   // Fields: mode write word lsb ctrl data acc sel
   chps_row_t rows [12] = '{
      '{2'h0, 1'b1, 1'b1, 1'b0, 1'b0, 16'h3c5a, 2'h3, 2'h0},
      '{2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0071, 2'h1, 2'h0},
      '{2'h0, 1'b1, 1'b0, 1'b1, 1'b0, 16'h0082, 2'h2, 2'h0},
      '{2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 16'hc3e1, 2'h3, 2'h0},
      '{2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 16'h9d42, 2'h2, 2'h0},
      '{2'h1, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0017, 2'h1, 2'h0},
      '{2'h1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h6b28, 2'h1, 2'h0},
      '{2'h1, 1'b0, 1'b0, 1'b1, 1'b0, 16'h6b28, 2'h2, 2'h0},
      '{2'h2, 1'b1, 1'b1, 1'b0, 1'b0, 16'hf00d, 2'h3, 2'h1},
      '{2'h2, 1'b1, 1'b1, 1'b0, 1'b1, 16'h0004, 2'h3, 2'h3},
      '{2'h2, 1'b0, 1'b1, 1'b0, 1'b1, 16'h00d0, 2'h3, 2'h2},
      '{2'h2, 1'b0, 1'b1, 1'b0, 1'b0, 16'h5150, 2'h3, 2'h1}
   };

   ////////////////////////////////////////////////////////////////////////////////
   chps_if u_chps_if ();
   chps_dev u_chps_dev (.mclk_i(mclk), .rst_n_i(rst_n), .bus(u_chps_if), .mode_i(mode),
      .udma_active_i(udma), .read_data_i(rd_src), .card_seated_o(seated),
      .is_master_o(master), .write_valid_o(wv), .write_data_o(wdat), .write_acc_o(wacc),
      .write_sel_o(wsel), .read_valid_o(rv), .read_acc_o(racc), .read_sel_o(rsel),
      .burst_stop_o(bstop));
   chps_host u_chps_host (.mclk_i(mclk), .rst_n_i(rst_n), .bus(u_chps_if), .mode_i(mode),
      .req_i(req), .req_write_i(req_wr), .req_word_i(req_word), .req_lsb_i(req_lsb),
      .req_ctrl_i(req_ctrl), .req_dma_i(req_dma), .req_master_i(req_master),
      .req_data_i(req_data), .stop_i(stop), .req_ready_o(ready), .done_o(done),
      .rd_data_o(rdat), .card_present_o(present));
   chps_checker u_chps_checker (.mclk_i(mclk), .rst_n_i(rst_n),
      .card_enable_low_byte_n(u_chps_if.card_enable_low_byte_n),
      .task_reg_select_n(u_chps_if.task_reg_select_n),
      .ctrl_reg_select_n(u_chps_if.ctrl_reg_select_n),
      .dma_acknowledge_n(u_chps_if.dma_acknowledge_n),
      .io_write_strobe_n(u_chps_if.io_write_strobe_n),
      .io_read_strobe_n(u_chps_if.io_read_strobe_n),
      .output_enable_n(u_chps_if.output_enable_n),
      .card_detect_first_n(u_chps_if.card_detect_first_n),
      .card_detect_second_n(u_chps_if.card_detect_second_n),
      .host_data(u_chps_if.host_data), .card_data_oe_n(u_chps_if.card_data_oe_n));

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #25 mclk = ~mclk;
   end

   // Catch one-cycle pulses and watchdog
   always @(posedge mclk) begin
      cyc++;
      if (wv === 1'b1) begin
         wv_seen = 1'b1;
         c_wacc = wacc;
         c_wsel = wsel;
         c_wdat = wdat;
      end
      if (rv === 1'b1) begin
         rv_seen = 1'b1;
         c_racc = racc;
         c_rsel = rsel;
      end
      if (done === 1'b1) dn_seen = 1'b1;
      if (bstop === 1'b1) bs_seen = 1'b1;
      if (cyc == 3000) begin
         n_fail++;
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic note(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         $display("wrong value %s expected %0h seen %0h", nm, e, g);
         n_fail++;
      end
   endtask
   task automatic chk_bit(input string nm, input logic e, input logic g);
      note(nm, 16'(e), 16'(g));
   endtask
   task automatic chk_data(input string nm, input logic [15:0] e, input logic [15:0] g);
      note(nm, e, g);
   endtask
   task automatic chk_acc(input string nm, input chps_pkg::chps_acc_t e,
      input chps_pkg::chps_acc_t g);
      note(nm, 16'(e), 16'(g));
   endtask
   task automatic chk_sel(input string nm, input chps_pkg::chps_sel_t e,
      input chps_pkg::chps_sel_t g);
      note(nm, 16'(e), 16'(g));
   endtask

   task automatic do_req(input chps_row_t r, input logic dma);
      wv_seen = 1'b0;
      rv_seen = 1'b0;
      dn_seen = 1'b0;
      @(negedge mclk);
      mode = chps_pkg::chps_mode_t'(r.mode);
      rd_src = r.data;
      req_wr = r.wr;
      req_word = r.word;
      req_lsb = r.lsb;
      req_ctrl = r.ctrl;
      req_dma = dma;
      req_data = r.data;
      req = 1'b1;
      for (int i = 0; i < 10 && ready !== 1'b1; i++) @(negedge mclk);
      @(negedge mclk);
      req = 1'b0;
      for (int i = 0; i < 20 && dn_seen !== 1'b1; i++) @(negedge mclk);
      repeat (6) @(negedge mclk);
   endtask

   task automatic run_row(input chps_row_t r);
      logic [15:0] exp;
      do_req(r, 1'b0);
      chk_bit("done", 1'b1, dn_seen);
      if (r.wr) begin
         chk_bit("write valid", 1'b1, wv_seen);
         chk_acc("write width", chps_pkg::chps_acc_t'(r.acc), c_wacc);
         if (r.mode == 2'h2) chk_sel("write sel", chps_pkg::chps_sel_t'(r.sel), c_wsel);
         if (r.word) chk_data("write data", r.data, c_wdat);
      end else begin
         chk_bit("read valid", 1'b1, rv_seen);
         chk_acc("read width", chps_pkg::chps_acc_t'(r.acc), c_racc);
         if (r.mode == 2'h2) chk_sel("read sel", chps_pkg::chps_sel_t'(r.sel), c_rsel);
         exp = r.word ? r.data : {8'h00, (r.lsb ? r.data[15:8] : r.data[7:0])};
         chk_data("read data", exp, r.word ? rdat : {8'h00, rdat[7:0]});
      end
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(negedge mclk);
      rst_n = 1'b1;
      for (int i = 0; i < 12; i++) begin
         run_row(rows[i]);
         $display("row %0d finished", i);
      end
      // Reset in the middle of a request
      @(negedge mclk);
      mode = chps_pkg::CHPS_MODE_MEM;
      req_wr = 1'b0;
      req = 1'b1;
      @(negedge mclk);
      req = 1'b0;
      repeat (2) @(negedge mclk);
      rst_n = 1'b0;
      repeat (2) @(negedge mclk);
      chk_bit("enable idle", 1'b1, u_chps_if.card_enable_low_byte_n);
      chk_bit("oe idle", 1'b1, u_chps_if.output_enable_n);
      chk_bit("card data off", 1'b1, u_chps_if.card_data_oe_n);
      chk_bit("cable_select_n tied", 1'b0, u_chps_if.cable_select_n);
      rst_n = 1'b1;
      @(negedge mclk);
      chk_bit("ready", 1'b1, ready);
      $display("reset test finished");
      // Cable select strap
      mode = chps_pkg::CHPS_MODE_IDE;
      req_master = 1'b1;
      repeat (5) @(negedge mclk);
      chk_bit("master", 1'b1, master);
      req_master = 1'b0;
      repeat (5) @(negedge mclk);
      chk_bit("slave", 1'b0, master);
      $display("strap test finished");
      // DMA transfer with selects negated
      do_req(rows[11], 1'b1);
      chk_bit("dma done", 1'b1, dn_seen);
      chk_bit("dma read valid", 1'b1, rv_seen);
      chk_acc("dma width", chps_pkg::CHPS_ACC_WORD, c_racc);
      chk_sel("dma sel", chps_pkg::CHPS_SEL_NONE, c_rsel);
      chk_data("dma data", rows[11].data, rdat);
      $display("dma test finished");
      // Stop request during an active burst
      udma = 1'b1;
      bs_seen = 1'b0;
      wv_seen = 1'b0;
      @(negedge mclk);
      stop = 1'b1;
      @(negedge mclk);
      stop = 1'b0;
      for (int i = 0; i < 12 && bs_seen !== 1'b1; i++) @(negedge mclk);
      chk_bit("burst stop", 1'b1, bs_seen);
      chk_bit("write blocked", 1'b0, wv_seen);
      udma = 1'b0;
      $display("stop test finished");
      chk_bit("seated", 1'b1, seated);
      chk_bit("present", 1'b1, present);
      $display("detect test finished");
      end_sim();
   end
endmodule
`default_nettype wire
